/* logic/fsq_pkg.sv */
// shared constants and types for the flash row erase and program sequencer
package fsq_pkg;
    // register port shape
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int PTR_W = 22;
    localparam int PTR_STEP_W = 21;
    localparam int HOLD_N = 8;
    localparam int HOLD_IDX_W = 3;
    localparam int ERASE_LSB = 6;
    localparam int PROG_LSB = 3;

    // register offsets
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_UNLOCK = 4'h1;
    localparam logic [3:0] OFF_LATCH = 4'h2;
    localparam logic [3:0] OFF_PTR_LOW = 4'h3;
    localparam logic [3:0] OFF_PTR_HIGH = 4'h4;
    localparam logic [3:0] OFF_PTR_UPPER = 4'h5;
    localparam logic [3:0] OFF_TABLE_WRITE_INSTR = 4'h6;

    // control register field positions
    localparam int BIT_PGM = 7;
    localparam int BIT_CFG = 6;
    localparam int BIT_ERASE = 4;
    localparam int BIT_WRITE_ENABLE_BIT = 2;
    localparam int BIT_WR = 1;

    // reset and key values
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
    localparam logic [7:0] HOLD_RESET = 8'hff;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // pointer moves on a table write command (low two bits of the command)
    localparam logic [1:0] TABLE_WRITE_INSTR_KEEP = 2'h0;
    localparam logic [1:0] TABLE_WRITE_INSTR_POSTINC = 2'h1;
    localparam logic [1:0] TABLE_WRITE_INSTR_POSTDEC = 2'h2;
    localparam logic [1:0] TABLE_WRITE_INSTR_PREINC = 2'h3;

    // timing: times in microseconds, clock in MHz
    localparam int CLK_MHZ = 40;
    localparam int TICK_CYCLES = CLK_MHZ;
    localparam int ERASE_TIME_US = 2000;
    localparam int PROG_TIME_US = 2000;
    localparam int TIME_W = 16;

    typedef enum logic [2:0] {
        FSQ_IDLE = 3'b001,
        FSQ_ERASE = 3'b010,
        FSQ_PROG = 3'b100
    } fsq_state_t;

    typedef enum logic [2:0] {
        FSQ_UNL_NONE = 3'b001,
        FSQ_UNL_KEY1 = 3'b010,
        FSQ_UNL_ARMED = 3'b100
    } fsq_unlock_t;
endpackage

/* logic/fsq_link_if.sv */
// carrier between the sequencer core, its holding bank and its timer
`timescale 1ns/1ps
`default_nettype none
interface fsq_link_if;
    import fsq_pkg::*;
    logic hb_wr;
    logic [HOLD_IDX_W-1:0] hb_idx;
    logic [DATA_W-1:0] hb_data;
    logic hb_clear;
    logic [HOLD_N*DATA_W-1:0] hb_flat;
    logic tmr_start;
    logic [TIME_W-1:0] tmr_us;
    logic tmr_done;

    modport core_mp (output hb_wr, hb_idx, hb_data, hb_clear, tmr_start, tmr_us,
                     input hb_flat, tmr_done);
    modport bank_mp (input hb_wr, hb_idx, hb_data, hb_clear, output hb_flat);
    modport timer_mp (input tmr_start, tmr_us, output tmr_done);
endinterface
`default_nettype wire

/* logic/fsq_hold_bank.sv */
// eight byte holding bank staged by table writes
`timescale 1ns/1ps
`default_nettype none
module fsq_hold_bank #(
    parameter int N = fsq_pkg::HOLD_N
) (
    input wire logic core_clk,
    input wire logic reset,
    fsq_link_if.bank_mp lnk
);
    import fsq_pkg::*;

    // one byte per slot, indexed by the low pointer bits
    generate
        for (genvar i = 0; i < N; i++) begin : g_slot
            logic [DATA_W-1:0] slot_q;
            logic hit;
            assign hit = lnk.hb_wr && (lnk.hb_idx == HOLD_IDX_W'(i));
            // clear wins: a finished operation leaves all slots erased-value
            always_ff @(posedge core_clk) begin
                if (reset || lnk.hb_clear) begin
                    slot_q <= HOLD_RESET;
                end else if (hit) begin
                    slot_q <= lnk.hb_data;
                end
            end
            assign lnk.hb_flat[i*DATA_W +: DATA_W] = slot_q;
        end
    endgenerate
endmodule // fsq_hold_bank
`default_nettype wire

/* logic/fsq_timer.sv */
// self-timed write/erase timer: microsecond tick divider and down counter
`timescale 1ns/1ps
`default_nettype none
module fsq_timer #(
    parameter int TICK = fsq_pkg::TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    fsq_link_if.timer_mp lnk
);
    import fsq_pkg::*;

    localparam int PW = $clog2(TICK + 1);
    localparam logic [PW-1:0] TICK_LAST = PW'(TICK - 1);

    logic [PW-1:0] pre_q;
    logic [TIME_W-1:0] us_q;
    logic run_q;
    logic tick;

    // one-cycle enable every microsecond while running
    assign tick = run_q && (pre_q == TICK_LAST);
    assign lnk.tmr_done = tick && (us_q == TIME_W'(1));

    // restarting from a start pulse keeps the length exact
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pre_q <= '0;
            us_q <= '0;
            run_q <= 1'b0;
        end else if (lnk.tmr_start) begin
            pre_q <= '0;
            us_q <= (lnk.tmr_us == '0) ? TIME_W'(1) : lnk.tmr_us;
            run_q <= 1'b1;
        end else if (run_q) begin
            pre_q <= tick ? '0 : pre_q + PW'(1);
            if (tick) begin
                us_q <= us_q - TIME_W'(1);
                run_q <= !lnk.tmr_done;
            end
        end
    end
endmodule // fsq_timer
`default_nettype wire

/* logic/fsq_sequencer.sv */
// flash row erase and block program sequencer: registers, unlock and control
// Overview of operation
// - unlocked write start with erase erases row
// - processor stalled for whole timed erase
// - programming works on whole 8-byte blocks only
// - eight holding registers staged by table writes
// - table write touches only one holding register
// - control write after loading starts long write
// - long write halts core, timer ends it
// - holding registers read FFh after reset, writes
// - FFh holding byte leaves flash byte unchanged
// - programming can only clear bits
// - partly loaded bank still programs, rest untouched
// - low three bits pick slot, upper nineteen block
// - erase uses upper sixteen bits, 64-byte row
// - write start set by software, cleared by hardware
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fsq_sequencer
    import fsq_pkg::*;
#(
    parameter int ERASE_US = fsq_pkg::ERASE_TIME_US,
    parameter int PROG_US = fsq_pkg::PROG_TIME_US,
    parameter int TICK = fsq_pkg::TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [fsq_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [fsq_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [fsq_pkg::DATA_W-1:0] reg_rdata,
    output logic cpu_stall,
    output logic flash_erase_start,
    output logic flash_prog_start,
    output logic [fsq_pkg::PTR_W-1:0] flash_addr,
    output logic [fsq_pkg::HOLD_N*fsq_pkg::DATA_W-1:0] flash_prog_data,
    output logic [fsq_pkg::HOLD_N-1:0] flash_prog_byte_en
);
    import fsq_pkg::*;

    // whole cycle lengths of the two timed operations
    localparam int ERASE_CYCLES = ERASE_US * TICK;
    localparam int PROG_CYCLES = PROG_US * TICK;
    localparam logic [TIME_W-1:0] ERASE_LEN = TIME_W'(ERASE_US);
    localparam logic [TIME_W-1:0] PROG_LEN = TIME_W'(PROG_US);

    // address decode used by both the write and the read side
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] off);
        hit = (a == ADDR_W'(off));
    endfunction

    // pointer arithmetic only moves the low 21 bits
    function automatic logic [PTR_W-1:0] step(input logic [PTR_W-1:0] p, input logic up);
        logic [PTR_STEP_W-1:0] low;
        low = up ? p[PTR_STEP_W-1:0] + PTR_STEP_W'(1) : p[PTR_STEP_W-1:0] - PTR_STEP_W'(1);
        step = {p[PTR_W-1:PTR_STEP_W], low};
    endfunction

    fsq_link_if lnk ();

    fsq_hold_bank #(
        .N(HOLD_N)
    ) u_bank (
        .core_clk(core_clk),
        .reset(reset),
        .lnk(lnk.bank_mp)
    );

    fsq_timer #(
        .TICK(TICK)
    ) u_timer (
        .core_clk(core_clk),
        .reset(reset),
        .lnk(lnk.timer_mp)
    );

    fsq_state_t state_q;
    fsq_state_t state_d;
    fsq_unlock_t unlock_q;
    fsq_unlock_t unlock_d;
    logic pgm_q;
    logic cfg_q;
    logic erase_q;
    logic write_enable_bit_q;
    logic [DATA_W-1:0] latch_q;
    logic [PTR_W-1:0] ptr_q;
    logic [PTR_W-1:0] ptr_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rd_mux;
    logic erase_start_q;
    logic prog_start_q;
    logic [PTR_W-1:0] faddr_q;
    logic [HOLD_N*DATA_W-1:0] fdata_q;
    logic [HOLD_N-1:0] fen_q;
    logic [HOLD_N-1:0] slot_used;

    // register write decode
    logic idle;
    logic busy;
    logic wr_ctrl;
    logic wr_unlock;
    logic wr_latch;
    logic wr_table_write_instr;
    logic ctrl_req_ok;
    logic start_req;
    logic start_erase;
    logic start_prog;
    logic op_done;
    logic [1:0] tbl_mode;
    logic [PTR_W-1:0] ptr_pre;

    assign idle = (state_q == FSQ_IDLE);
    assign busy = !idle;
    assign wr_ctrl = reg_wr && hit(reg_addr, OFF_CTRL);
    assign wr_unlock = reg_wr && hit(reg_addr, OFF_UNLOCK);
    assign wr_latch = reg_wr && hit(reg_addr, OFF_LATCH);
    assign wr_table_write_instr = reg_wr && hit(reg_addr, OFF_TABLE_WRITE_INSTR) && idle;
    assign op_done = lnk.tmr_done;

    // start needs the armed unlock pair right before, and a program-space write
    assign ctrl_req_ok = reg_wdata[BIT_WRITE_ENABLE_BIT] && reg_wdata[BIT_PGM] && !reg_wdata[BIT_CFG];
    assign start_req = wr_ctrl && idle && reg_wdata[BIT_WR] && ctrl_req_ok
                       && (unlock_q == FSQ_UNL_ARMED);
    assign start_erase = start_req && reg_wdata[BIT_ERASE];
    assign start_prog = start_req && !reg_wdata[BIT_ERASE];

    // unlock tracker: any other write in between breaks the pair
    always_comb begin
        unlock_d = FSQ_UNL_NONE;
        if (!reg_wr) begin
            unlock_d = unlock_q;
        end else if (wr_unlock && write_enable_bit_q && reg_wdata == UNLOCK_KEY1) begin
            unlock_d = FSQ_UNL_KEY1;
        end else if (wr_unlock && write_enable_bit_q && reg_wdata == UNLOCK_KEY2
                     && unlock_q == FSQ_UNL_KEY1) begin
            unlock_d = FSQ_UNL_ARMED;
        end
    end

    // table write: pre-increment selects the slot after the move
    assign tbl_mode = reg_wdata[1:0];
    assign ptr_pre = (tbl_mode == TABLE_WRITE_INSTR_PREINC) ? step(ptr_q, 1'b1) : ptr_q;

    // short write into one holding slot, flash untouched
    assign lnk.hb_wr = wr_table_write_instr;
    assign lnk.hb_idx = ptr_pre[HOLD_IDX_W-1:0];
    assign lnk.hb_data = latch_q;
    assign lnk.hb_clear = op_done;

    // one timer serves both operations
    assign lnk.tmr_start = start_req;
    assign lnk.tmr_us = start_erase ? ERASE_LEN : PROG_LEN;

    // pointer next value from byte writes and table write moves
    always_comb begin
        ptr_d = ptr_q;
        if (reg_wr && idle && hit(reg_addr, OFF_PTR_LOW)) begin
            ptr_d[7:0] = reg_wdata;
        end else if (reg_wr && idle && hit(reg_addr, OFF_PTR_HIGH)) begin
            ptr_d[15:8] = reg_wdata;
        end else if (reg_wr && idle && hit(reg_addr, OFF_PTR_UPPER)) begin
            ptr_d[PTR_W-1:16] = reg_wdata[PTR_W-17:0];
        end else if (wr_table_write_instr) begin
            case (tbl_mode)
                TABLE_WRITE_INSTR_POSTINC: ptr_d = step(ptr_q, 1'b1);
                TABLE_WRITE_INSTR_POSTDEC: ptr_d = step(ptr_q, 1'b0);
                TABLE_WRITE_INSTR_PREINC: ptr_d = ptr_pre;
                default: ptr_d = ptr_q;
            endcase
        end
    end

    // operation state: idle until a start, back when the timer ends it
    always_comb begin
        state_d = state_q;
        case (state_q)
            FSQ_IDLE: begin
                if (start_erase) begin
                    state_d = FSQ_ERASE;
                end else if (start_prog) begin
                    state_d = FSQ_PROG;
                end
            end
            FSQ_ERASE: begin
                if (op_done) begin
                    state_d = FSQ_IDLE;
                end
            end
            FSQ_PROG: begin
                if (op_done) begin
                    state_d = FSQ_IDLE;
                end
            end
            default: state_d = FSQ_IDLE;
        endcase
    end

    // a slot still holding the erased value is masked off
    generate
        for (genvar i = 0; i < HOLD_N; i++) begin : g_used
            assign slot_used[i] = (lnk.hb_flat[i*DATA_W +: DATA_W] != HOLD_RESET);
        end
    endgenerate

    // sequencer state and software-visible bits
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= FSQ_IDLE;
            unlock_q <= FSQ_UNL_NONE;
            ptr_q <= '0;
            latch_q <= ZERO_BYTE;
        end else begin
            state_q <= state_d;
            unlock_q <= unlock_d;
            ptr_q <= ptr_d;
            if (wr_latch) begin
                latch_q <= reg_wdata;
            end
        end
    end

    // control bits are frozen while an operation runs
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pgm_q <= 1'b0;
            cfg_q <= 1'b0;
            erase_q <= 1'b0;
            write_enable_bit_q <= 1'b0;
        end else if (wr_ctrl && idle) begin
            pgm_q <= reg_wdata[BIT_PGM];
            cfg_q <= reg_wdata[BIT_CFG];
            erase_q <= reg_wdata[BIT_ERASE];
            write_enable_bit_q <= reg_wdata[BIT_WRITE_ENABLE_BIT];
        end
    end

    // launch to the flash array: row for erase, 8-byte block for program
    always_ff @(posedge core_clk) begin
        if (reset) begin
            erase_start_q <= 1'b0;
            prog_start_q <= 1'b0;
            faddr_q <= '0;
            fdata_q <= '1;
            fen_q <= '0;
        end else begin
            erase_start_q <= start_erase;
            prog_start_q <= start_prog;
            if (start_erase) begin
                faddr_q <= {ptr_q[PTR_W-1:ERASE_LSB], ERASE_LSB'(0)};
                fen_q <= '0;
            end else if (start_prog) begin
                faddr_q <= {ptr_q[PTR_W-1:PROG_LSB], PROG_LSB'(0)};
                fdata_q <= lnk.hb_flat;
                fen_q <= slot_used;
            end
        end
    end

    // read mux; write start reads back as busy until hardware clears it
    always_comb begin
        rd_mux = ZERO_BYTE;
        if (hit(reg_addr, OFF_CTRL)) begin
            rd_mux[BIT_PGM] = pgm_q;
            rd_mux[BIT_CFG] = cfg_q;
            rd_mux[BIT_ERASE] = erase_q;
            rd_mux[BIT_WRITE_ENABLE_BIT] = write_enable_bit_q;
            rd_mux[BIT_WR] = busy;
        end else if (hit(reg_addr, OFF_LATCH)) begin
            rd_mux = latch_q;
        end else if (hit(reg_addr, OFF_PTR_LOW)) begin
            rd_mux = ptr_q[7:0];
        end else if (hit(reg_addr, OFF_PTR_HIGH)) begin
            rd_mux = ptr_q[15:8];
        end else if (hit(reg_addr, OFF_PTR_UPPER)) begin
            rd_mux = {2'h0, ptr_q[PTR_W-1:16]};
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata_q <= ZERO_BYTE;
        end else begin
            rdata_q <= reg_rd ? rd_mux : ZERO_BYTE;
        end
    end

    assign reg_rdata = rdata_q;
    assign cpu_stall = busy;
    assign flash_erase_start = erase_start_q;
    assign flash_prog_start = prog_start_q;
    assign flash_addr = faddr_q;
    assign flash_prog_data = fdata_q;
    assign flash_prog_byte_en = fen_q;
endmodule // fsq_sequencer
`default_nettype wire

/* test/fsq_sequencer_asserts.sv */
// port-level checks for the flash sequencer top
`timescale 1ns/1ps
`default_nettype none
module fsq_sequencer_asserts
    import fsq_pkg::*;
#(
    parameter int ERASE_US = fsq_pkg::ERASE_TIME_US,
    parameter int PROG_US = fsq_pkg::PROG_TIME_US,
    parameter int TICK = fsq_pkg::TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [fsq_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [fsq_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [fsq_pkg::DATA_W-1:0] reg_rdata,
    input wire logic cpu_stall,
    input wire logic flash_erase_start,
    input wire logic flash_prog_start,
    input wire logic [fsq_pkg::PTR_W-1:0] flash_addr,
    input wire logic [fsq_pkg::HOLD_N*fsq_pkg::DATA_W-1:0] flash_prog_data,
    input wire logic [fsq_pkg::HOLD_N-1:0] flash_prog_byte_en
);
    // zero length behaves as one microsecond
    localparam int ERASE_N = (ERASE_US < 1 ? 1 : ERASE_US) * TICK;
    localparam int PROG_N = (PROG_US < 1 ? 1 : PROG_US) * TICK;
    // wide enough for a full-length run at the real tick rate
    logic [31:0] stall_cnt_q;
    logic erase_run_q;
    logic [HOLD_N-1:0] live_bytes;
    logic any_start;
    assign any_start = flash_erase_start | flash_prog_start;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // length of the current stall, and which kind of run it is
    always_ff @(posedge core_clk) begin
        stall_cnt_q <= (reset || !cpu_stall) ? 32'h00000000 : stall_cnt_q + 32'h00000001;
        erase_run_q <= reset ? 1'b0 : (flash_erase_start | (erase_run_q & ~flash_prog_start));
    end
    // bytes that differ from the erased value
    always_comb begin
        for (int i = 0; i < HOLD_N; i++) begin
            live_bytes[i] = (flash_prog_data[8*i +: 8] != HOLD_RESET);
        end
    end
    a_erase_len_exact: assert property ($fell(cpu_stall) && erase_run_q |-> stall_cnt_q == ERASE_N)
        else $error("erase stall length wrong");
    a_prog_len_exact: assert property ($fell(cpu_stall) && !erase_run_q |-> stall_cnt_q == PROG_N)
        else $error("program stall length wrong");
    a_stall_bound: assert property (cpu_stall && !any_start |->
        stall_cnt_q < (erase_run_q ? ERASE_N : PROG_N))
        else $error("stall outlives timer");
    a_start_cause: assert property (any_start |-> $past(reg_wr) && $past(reg_addr) == OFF_CTRL
        && ($past(reg_wdata) & 8'hc6) == 8'h86 && !$past(cpu_stall))
        else $error("start without control write");
    a_erase_select: assert property (flash_erase_start |-> ($past(reg_wdata) & 8'h10) != 8'h00)
        else $error("erase start without erase select");
    a_start_stalls: assert property (any_start |-> $rose(cpu_stall) ##1 !any_start)
        else $error("start pulse without stall");
    a_erase_row: assert property (flash_erase_start |-> flash_addr[5:0] == 6'h00
        && flash_prog_byte_en == 8'h00)
        else $error("erase address not row aligned");
    a_prog_block: assert property (flash_prog_start |-> flash_addr[2:0] == 3'h0)
        else $error("program address not block aligned");
    a_prog_mask: assert property (flash_prog_start |-> flash_prog_byte_en == live_bytes)
        else $error("byte enables do not match data");
    a_no_restart: assert property (cpu_stall && $past(cpu_stall) |-> !any_start)
        else $error("start while busy");
    c_erase: cover property (flash_erase_start);
    c_prog: cover property (flash_prog_start);
    c_prog_done: cover property ($fell(cpu_stall) && !erase_run_q);
endmodule // fsq_sequencer_asserts
`default_nettype wire

/* test/fsq_sequencer_test.sv */
// self-checking bench for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module fsq_sequencer_test;
    import fsq_pkg::*;
    // shortened timer so each run lasts a few cycles
    localparam int ERASE_US = 3;
    localparam int PROG_US = 2;
    localparam int TICK = 2;
    logic core_clk;
    logic reset;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic cpu_stall;
    logic flash_erase_start;
    logic flash_prog_start;
    logic [PTR_W-1:0] flash_addr;
    logic [HOLD_N*DATA_W-1:0] flash_prog_data;
    logic [HOLD_N-1:0] flash_prog_byte_en;
    int err_count;
    int compares;
    fsq_sequencer #(.ERASE_US(ERASE_US), .PROG_US(PROG_US), .TICK(TICK)) DUT (
        .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_stall(cpu_stall),
        .flash_erase_start(flash_erase_start), .flash_prog_start(flash_prog_start),
        .flash_addr(flash_addr), .flash_prog_data(flash_prog_data),
        .flash_prog_byte_en(flash_prog_byte_en)
    );
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // one-cycle write strobe; returns on the taking edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic set_ptr(input logic [21:0] p);
        wr(OFF_PTR_UPPER, {2'b00, p[21:16]});
        wr(OFF_PTR_HIGH, p[15:8]);
        wr(OFF_PTR_LOW, p[7:0]);
    endtask
    task automatic tw(input logic [7:0] d, input logic [1:0] mode);
        wr(OFF_LATCH, d);
        wr(OFF_TABLE_WRITE_INSTR, {6'h00, mode});
    endtask
    // arm with write_enable_bit, two keys (optionally split), then the start write
    task automatic launch(input logic [7:0] ctl, input logic [7:0] k1, input logic [7:0] k2,
                          input logic gap);
        wr(OFF_CTRL, ctl & 8'hfd);
        wr(OFF_UNLOCK, k1);
        if (gap) wr(4'hf, 8'h00);
        wr(OFF_UNLOCK, k2);
        wr(OFF_CTRL, ctl);
        #1;
    endtask
    task automatic expect_run(input logic er, input logic [21:0] addr, input logic [63:0] data,
                              input logic [7:0] ben, input int n);
        int cyc;
        logic [7:0] v;
        chk("erase start", er, flash_erase_start);
        chk("prog start", !er, flash_prog_start);
        chk("flash addr", addr, flash_addr);
        if (!er) begin
            chk("prog data", data, flash_prog_data);
            chk("byte enables", ben, flash_prog_byte_en);
        end
        cyc = 0;
        while (cpu_stall === 1'b1 && cyc < 100) begin
            @(posedge core_clk);
            #1;
            cyc++;
        end
        chk("stall cycles", n, cyc);
        rd(OFF_CTRL, v);
        chk("write start bit", 1'b0, v[BIT_WR]);
    endtask
    task automatic run_reset_values();
        logic [7:0] v;
        chk("reset data", {8{HOLD_RESET}}, flash_prog_data);
        chk("reset byte en", 8'h00, flash_prog_byte_en);
        rd(OFF_CTRL, v);
        chk("reset ctrl", 8'h00, v);
        rd(4'hf, v);
        chk("unmapped", 8'h00, v);
    endtask
    // erase ignores the six low pointer bits
    task automatic run_erase();
        logic [7:0] v;
        set_ptr(22'h12347f);
        launch(8'h96, UNLOCK_KEY1, UNLOCK_KEY2, 1'b0);
        expect_run(1'b1, 22'h123440, 64'h0, 8'h00, ERASE_US * TICK);
        rd(OFF_PTR_LOW, v);
        chk("pointer kept", 8'h7f, v);
    endtask
    // wrong order, split keys, config space, no write_enable_bit: none may start
    task automatic run_refusals();
        logic [7:0] ctl[4] = '{8'h96, 8'h96, 8'hd6, 8'h92};
        logic [7:0] k1[4] = '{UNLOCK_KEY2, UNLOCK_KEY1, UNLOCK_KEY1, UNLOCK_KEY1};
        logic [7:0] k2[4] = '{UNLOCK_KEY1, UNLOCK_KEY2, UNLOCK_KEY2, UNLOCK_KEY2};
        logic gap[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 4; i++) begin
            launch(ctl[i], k1[i], k2[i], gap[i]);
            chk("refused stall", 1'b0, cpu_stall);
            chk("refused start", 2'b00, {flash_erase_start, flash_prog_start});
        end
    endtask
    // partial block through all four pointer moves, then an empty block
    task automatic run_program();
        logic [7:0] v;
        set_ptr(22'h00ab0d);
        tw(8'h3c, TABLE_WRITE_INSTR_POSTINC);
        tw(8'ha5, TABLE_WRITE_INSTR_PREINC);
        tw(8'h00, TABLE_WRITE_INSTR_POSTDEC);
        tw(8'h5a, TABLE_WRITE_INSTR_KEEP);
        rd(OFF_PTR_LOW, v);
        chk("pointer moves", 8'h0e, v);
        launch(8'h86, UNLOCK_KEY1, UNLOCK_KEY2, 1'b0);
        expect_run(1'b0, 22'h00ab08, 64'h005a3cff_ffffffff, 8'he0, PROG_US * TICK);
        launch(8'h86, UNLOCK_KEY1, UNLOCK_KEY2, 1'b0);
        expect_run(1'b0, 22'h00ab08, {8{HOLD_RESET}}, 8'h00, PROG_US * TICK);
        // full eight-write block; the moves wrap in the low 21 pointer bits only
        set_ptr(22'h3ffff8);
        for (int i = 0; i < 8; i++) begin
            tw(8'(i * 17), TABLE_WRITE_INSTR_POSTINC);
        end
        rd(OFF_PTR_UPPER, v);
        chk("pointer wrap", 8'h20, v);
        rd(OFF_PTR_HIGH, v);
        chk("pointer high", 8'h00, v);
        rd(OFF_LATCH, v);
        chk("latch readback", 8'h77, v);
        launch(8'h86, UNLOCK_KEY1, UNLOCK_KEY2, 1'b0);
        expect_run(1'b0, 22'h200000, 64'h77665544_33221100, 8'hff, PROG_US * TICK);
    endtask
    task automatic wrap_up();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        reset = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        err_count = 0;
        compares = 0;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        run_reset_values();
        run_erase();
        run_refusals();
        run_program();
        wrap_up();
    end
    // the whole run needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge core_clk);
        err_count++;
        $display("unexpected watchdog: expected done seen hang");
        wrap_up();
    end
endmodule // fsq_sequencer_test
bind fsq_sequencer fsq_sequencer_asserts #(.ERASE_US(ERASE_US), .PROG_US(PROG_US), .TICK(TICK))
    u_chk (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_stall(cpu_stall),
    .flash_erase_start(flash_erase_start), .flash_prog_start(flash_prog_start),
    .flash_addr(flash_addr), .flash_prog_data(flash_prog_data),
    .flash_prog_byte_en(flash_prog_byte_en));
`default_nettype wire
